/* verification/dsts_drive_model.sv */
// Purpose: Behavioural drive unit answering the sequencer
// Assumes: Flag period shortened to FLAG_CYC+1 clocks
// Notes:   Logs each write word seen with a reset flag
`timescale 1ns/1ps
module dsts_drive_model
  import dsts_pkg::*;
#(
  parameter int FLAG_CYC = 40
) (
  input  wire logic          mclk,
  input  wire logic          mute,
  input  wire dsts_chan_type chan_out,
  output logic [15:0]        status_word = 16'h0000,
  output logic [15:0]        rdata_word = 16'h5a5a
);
  logic [15:0] log_q [0:255];
  logic [15:0] acc = 16'h0000;
  logic        armed = 1'b0;
  int          n_log = 0, cnt = 0, nrd = 0;
  // ************************************************
  // Flag pacing, one word per flag
  // ************************************************
  always @(posedge mclk) begin
    if (chan_out.ctl[CTL_ZERO_POS]) armed <= 1'b1;
    if (!chan_out.tag_sel[TAG_CTRL_POS] || mute) begin
      armed <= 1'b0;
      cnt <= 0;
      nrd <= 0;
      acc <= 16'h0000;
    end else if (armed || chan_out.ctl[BUS_LSB+BUS_WGATE] && chan_out.ctl[BUS_LSB+BUS_ERASE]) begin
      cnt <= (cnt == FLAG_CYC) ? 0 : cnt + 1;
      if (cnt == FLAG_CYC) begin
        status_word[STS_FLAG_POS] <= 1'b1;
        rdata_word <= (nrd < DATA_WORDS) ? 16'(nrd + 1) : {acc[7:0], acc[15:8]};
        acc <= acc ^ 16'(nrd + 1);
        nrd <= nrd + 1;
      end
    end
    // Data line no longer held once the word is taken
    if (chan_out.ctl[CTL_RFLAG_POS]) begin
      status_word[STS_FLAG_POS] <= 1'b0;
      rdata_word <= ~rdata_word;
      log_q[n_log[7:0]] <= chan_out.wdata;
      n_log <= n_log + 1;
    end
  end
endmodule : dsts_drive_model

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the disk sector transfer sequencer
// Assumes: Short gap and window counts; drive model paces flags
// Notes:   Reset, sector write, sector read, flag timeout
`timescale 1ns/1ps
module tb_top;
  import dsts_pkg::*;
  logic          mclk, rst_n, hsel, hwrite, hrdy, mute;
  logic [1:0]    htrans;
  logic [31:0]   haddr, hwdata, hrdata, r, st;
  logic          hresp_s;
  logic [15:0]   sts, rdw;
  dsts_chan_type chan;
  int            error_cnt = 0, compares = 0, b;
  dsts_host #(.GAP_CYCLES(20), .HWIN_CYCLES(50)) DUT (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hresp(hresp_s), .hrdata(hrdata), .chan_out(chan), .drive_status_in_word(sts), .read_data_in_word(rdw));
  dsts_drive_model DRV (.mclk(mclk), .mute(mute), .chan_out(chan), .status_word(sts), .rdata_word(rdw));
  // Free running clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic finish_test;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [47:0] g, input logic [47:0] e, input string m);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : cmp
  // One single transfer; hold until hready seen high at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {24'h0, a};
    // Address phase stands until hready is seen high at a rising edge
    do begin
      @(posedge mclk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    // Data phase ends, and read data is taken, at the next edge with hready high
    do begin
      @(posedge mclk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    r = hrdata;
    if (n >= 50) begin
      cmp(0, 1, "bus hang");
      finish_test;
    end
  endtask : bus
  // Status seen with done is kept in st, since the clearing write returns zero
  task automatic run_op(input logic [2:0] op, input logic [31:0] x);
    bus(1'b1, REG_CTRL, 32'h1 | (32'(op) << 1) | (32'h5 << 6) | x);
    for (int i = 0; i < 3000; i++) begin
      bus(1'b0, REG_STATUS, 0);
      if (r[ST_DONE] === 1'b1) break;
    end
    st = r;
    if (st[ST_DONE] !== 1'b1) begin
      cmp(0, 1, "no done");
      finish_test;
    end
    bus(1'b1, REG_STATUS, 32'he);
  endtask : run_op
  task automatic t_write;
    bus(1'b1, REG_BUF_IDX, 0);
    bus(1'b1, REG_BUF_DATA, 32'h1234);
    b = DRV.n_log;
    run_op(OP_WRSEC, 0);
    for (int i = 0; i < 8; i++) cmp(DRV.log_q[b+i], i < 5 ? WORD_ONES : WORD_SYNC, "lead words");
    cmp(DRV.log_q[b+8], 32'h1234, "first data");
    cmp(DRV.log_q[b+113], WORD_SYNC, "end word");
    cmp(DRV.n_log - b, 115, "flag count");
    cmp({chan.tag_sel, chan.ctl[15:3]}, 0, "write cleared");
    $display("test write done");
  endtask : t_write
  // Sector tag out, then a tag write with half tracking on
  task automatic t_tag;
    run_op(OP_TAGOUT, 32'h00ff_0200);
    cmp(st[ST_TOUT], 0, "tag out");
    bus(1'b1, REG_TAG, 32'h0f35);
    b = DRV.n_log;
    run_op(OP_WRTAG, 32'h10);
    cmp(DRV.log_q[b+7], 16'h0f35, "tag word");
    cmp(DRV.log_q[b+8], 16'hf0ca, "tag check");
    cmp(DRV.n_log - b, 10, "tag flags");
    bus(1'b0, REG_STATUS, 0);
    cmp(r[ST_HWIN], 1, "half window");
    $display("test tag done");
  endtask : t_tag
  task automatic t_read;
    b = DRV.n_log;
    run_op(OP_RDSEC, 0);
    cmp(st[ST_CERR], 0, "check error");
    cmp(DRV.log_q[b+50], WORD_ONES, "out ones");
    bus(1'b1, REG_BUF_IDX, 0);
    for (int i = 1; i < 3; i++) begin
      bus(1'b0, REG_BUF_DATA, 0);
      cmp(r[15:0], i, "read word");
    end
    $display("test read done");
  endtask : t_read
  task automatic t_tout;
    mute <= 1'b1;
    run_op(OP_RDSEC, 0);
    cmp(st[ST_TOUT], 1, "timeout");
    cmp(chan.ctl[15:3], 0, "tout cleared");
    run_op(OP_TAGRD, 32'h20);
    cmp(st[ST_TOUT], 1, "tag read timeout");
    cmp(chan.wdata, 0, "zeros before write");
    mute <= 1'b0;
    $display("test timeout done");
  endtask : t_tout
  // Main sequence
  initial begin
    rst_n = 1'b0; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0; haddr = '0; hwdata = '0; mute = 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    cmp(chan, CHAN_RST, "reset value");
    cmp(hresp_s, 0, "okay response");
    t_write;
    t_read;
    t_tag;
    t_tout;
    finish_test;
  end
endmodule : tb_top

/* verilog/dsts_host.sv */
// Purpose: Controller that drives a removable-pack disk interface through its channel words
// Assumes: Software orders operations over AHB-Lite; drive status and read data arrive asynchronously
// Notes:   Each bus transfer takes one wait state; sector data sits in a local 104 word buffer
//
// Summary of operation
// - Difference tag uses bus bits 0-5; sector and head tags use bits 0-3.
// - Every wait for the flag is bounded by a timeout.
// - After the tag word, wait next flag and check complement checkword.
// - After tag check, output word ones before read, zeros before write.
// - Sector read starts with a 45 us head gap wait.
// - Read pulses zeros search, then waits for flag leading edge.
// - Read takes 104 words and a checkword, one per flag edge.
// - Read data good only if xor of words equals checkword rotated left eight.
// - Half tracking: restart selection within 1.6 ms after read or write.
// - Write sets write bit, erase, write gate, control tag in order, waits flag.
// - Write stream: 5 gap, 3 sync, 104 data, checkword, end-of-record.
// - Each write word is loaded on one flag leading edge.
// - At stream end, write, erase, write gate and control tag are cleared.
// - Tag write stream: 5 gap, 2 sync, tag, tag complement.
// - Unit select code is held steady for the whole operation.
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module dsts_host
  import dsts_pkg::*;
#(
  parameter int GAP_CYCLES  = GAP_CYC,
  parameter int HWIN_CYCLES = HALF_WIN_CYC
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  output dsts_chan_type      chan_out,
  input  wire logic [15:0]   drive_status_in_word,
  input  wire logic [15:0]   read_data_in_word
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum {S_IDLE, S_GAP, S_ZSET, S_ZCLR, S_SETWR, S_SETER, S_SETWG, S_SETTAG,
                S_FWAIT, S_FACK, S_HOLD, S_FIN} dsts_state_type;
  dsts_state_type state_q;
  logic          rst_s1_q, rst_n_q;
  logic [15:0]   sts_s1_q, sts_s2_q, dat_s1_q, dat_s2_q;
  logic          flag_prev_q, flag_rise;
  logic          pend_q, wr_q;
  logic [7:0]    addr_q;
  logic [31:0]   ctrl_q;
  logic [15:0]   tag_wr_q, tag_rd_q;
  logic [6:0]    bidx_q;
  logic [15:0]   buf_mem [0:DATA_WORDS-1];
  logic [4:0]    sts_q;
  logic [7:0]    widx_q;
  logic [15:0]   acc_q;
  logic [17:0]   cnt_q, hwin_q;
  dsts_op_type   op_q;
  dsts_chan_type chan_q;
  logic          wr_en, rd_en, start, hwin_go;
  logic [15:0]   out_word, buf_rd;
  logic [31:0]   rd_val;
  logic          hsize_unused_ok;

  // Word size only; any other size is still served as a whole word
  assign hsize_unused_ok = (hsize == 3'h2);
  assign flag_rise = sts_s2_q[STS_FLAG_POS] & ~flag_prev_q;
  assign wr_en     = pend_q & wr_q;
  assign rd_en     = pend_q & ~wr_q;
  assign start     = wr_en && addr_q == REG_CTRL && hwdata[CTRL_START] && state_q == S_IDLE;
  assign chan_out  = chan_q;

  // Stream lengths; write streams need one more flag so the last word shifts out
  function automatic logic [7:0] op_len(input dsts_op_type op);
    case (op)
      OP_TAGRD: op_len = TR_LEN;
      OP_RDSEC: op_len = RD_LEN;
      OP_WRSEC: op_len = 8'(WS_LEN + 8'h01);
      OP_WRTAG: op_len = 8'(WT_LEN + 8'h01);
      default:  op_len = 8'h00;
    endcase
  endfunction : op_len

  // ****************************************************************
  // Reset release and input synchronisers
  // ****************************************************************
  // Two stage release keeps the async assert but a clean deassert
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Drive words come from another domain; only the second stage is used
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sts_s1_q    <= 16'h0000;
      sts_s2_q    <= 16'h0000;
      dat_s1_q    <= 16'h0000;
      dat_s2_q    <= 16'h0000;
      flag_prev_q <= 1'b0;
    end else begin
      sts_s1_q    <= drive_status_in_word;
      sts_s2_q    <= sts_s1_q;
      dat_s1_q    <= read_data_in_word;
      dat_s2_q    <= dat_s1_q;
      flag_prev_q <= sts_s2_q[STS_FLAG_POS];   // Leading edge only
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // One wait state per transfer so read data leaves a flip-flop
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q    <= 1'b0;
      wr_q      <= 1'b0;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      pend_q <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        pend_q    <= 1'b1;
        wr_q      <= hwrite;
        addr_q    <= haddr[7:0];
        hreadyout <= 1'b0;
      end
      if (pend_q) begin
        hreadyout <= 1'b1;
        hrdata    <= wr_q ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // Read multiplexer; unmapped words read zero
  always_comb begin
    case (addr_q)
      REG_CTRL:     rd_val = {ctrl_q[31:1], 1'b0};
      REG_STATUS:   rd_val = {27'h0000000, sts_q};
      REG_TAG:      rd_val = {tag_rd_q, tag_wr_q};
      REG_BUF_IDX:  rd_val = {25'h0000000, bidx_q};
      REG_BUF_DATA: rd_val = {16'h0000, buf_rd};
      default:      rd_val = 32'h0000_0000;
    endcase
  end

  // Software registers; unit settings are frozen while busy, the tag word can be written at any time
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q   <= 32'h0000_0000;
      tag_wr_q <= 16'h0000;
      bidx_q   <= 7'h00;
    end else if (pend_q) begin
      if (wr_en && addr_q == REG_CTRL && state_q == S_IDLE) ctrl_q <= hwdata;
      if (wr_en && addr_q == REG_TAG) tag_wr_q <= hwdata[15:0];
      if (wr_en && addr_q == REG_BUF_IDX) bidx_q <= hwdata[6:0];
      if (addr_q == REG_BUF_DATA) bidx_q <= (bidx_q == 7'(DATA_WORDS - 1)) ? 7'h00 : 7'(bidx_q + 7'h01);
    end
  end

  // ****************************************************************
  // Sector buffer
  // ****************************************************************
  assign buf_rd = (widx_q >= 8'(GAP_WORDS + WS_SYNC) && op_q == OP_WRSEC && state_q != S_IDLE)
                  ? buf_mem[7'(widx_q - 8'(GAP_WORDS + WS_SYNC))] : buf_mem[bidx_q];

  // Sequencer capture has priority; software cannot write while a read runs
  always_ff @(posedge mclk) begin
    if (state_q == S_FWAIT && flag_rise && op_q == OP_RDSEC && widx_q < 8'(DATA_WORDS))
      buf_mem[7'(widx_q)] <= dat_s2_q;
    else if (wr_en && addr_q == REG_BUF_DATA && state_q == S_IDLE)
      buf_mem[bidx_q] <= hwdata[15:0];
  end

  // ****************************************************************
  // Write stream words
  // ****************************************************************
  // Checkword is the running xor rotated right so a reader's rotate left matches
  always_comb begin
    out_word = WORD_ONES;
    if (op_q == OP_WRSEC) begin
      if (widx_q < 8'(GAP_WORDS)) out_word = WORD_ONES;
      else if (widx_q < 8'(GAP_WORDS + WS_SYNC)) out_word = WORD_SYNC;
      else if (widx_q < 8'(GAP_WORDS + WS_SYNC + DATA_WORDS)) out_word = buf_rd;
      else if (widx_q == 8'(GAP_WORDS + WS_SYNC + DATA_WORDS)) out_word = {acc_q[7:0], acc_q[15:8]};
      else out_word = WORD_SYNC;
    end else begin
      if (widx_q < 8'(GAP_WORDS)) out_word = WORD_ONES;
      else if (widx_q < 8'(GAP_WORDS + WT_SYNC)) out_word = WORD_SYNC;
      else if (widx_q == 8'(GAP_WORDS + WT_SYNC)) out_word = tag_wr_q;
      else out_word = ~tag_wr_q;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q  <= S_IDLE;
      op_q     <= OP_TAGOUT;
      chan_q   <= CHAN_RST;
      widx_q   <= 8'h00;
      acc_q    <= 16'h0000;
      cnt_q    <= 18'h00000;
      tag_rd_q <= 16'h0000;
      sts_q    <= 5'h00;
      hwin_go  <= 1'b0;
    end else begin
      hwin_go <= 1'b0;
      // Unit code loads with the start, so it never moves inside an operation
      if (start) chan_q.ctl[CTL_UNIT_LSB +: 3] <= hwdata[CTRL_UNIT_LSB +: 3];
      // Software clears status with ones; a same-cycle event set below wins
      if (wr_en && addr_q == REG_STATUS) sts_q[ST_CERR:ST_DONE] <= sts_q[ST_CERR:ST_DONE] & ~hwdata[ST_CERR:ST_DONE];
      sts_q[ST_BUSY] <= state_q != S_IDLE;
      sts_q[ST_HWIN] <= hwin_q != 18'h00000;
      case (state_q)
        S_IDLE: begin
          if (start) begin
            op_q   <= dsts_op_type'(hwdata[CTRL_OP_LSB +: 3]);
            widx_q <= 8'h00;
            acc_q  <= 16'h0000;
            cnt_q  <= 18'(FLAG_TO_CYC);
            case (dsts_op_type'(hwdata[CTRL_OP_LSB +: 3]))
              OP_TAGOUT: begin
                cnt_q <= 18'(TAG_HOLD_CYC);
                state_q <= S_HOLD;
                case (hwdata[CTRL_KIND_LSB +: 2])
                  2'd0: begin
                    chan_q.tag_sel[TAG_DIFF_POS] <= 1'b1;
                    chan_q.ctl[BUS_LSB +: 8] <= hwdata[CTRL_BUS_LSB +: 8] & MASK_DIFF;
                  end
                  2'd1: begin
                    chan_q.tag_sel[TAG_SECT_POS] <= 1'b1;
                    chan_q.ctl[BUS_LSB +: 8] <= hwdata[CTRL_BUS_LSB +: 8] & MASK_SH;
                  end
                  2'd2: begin
                    chan_q.tag_sel[TAG_HEAD_POS] <= 1'b1;
                    chan_q.ctl[BUS_LSB +: 8] <= hwdata[CTRL_BUS_LSB +: 8] & MASK_SH;
                  end
                  default: begin
                    chan_q.tag_sel[TAG_CTRL_POS] <= 1'b1;
                    chan_q.ctl[BUS_LSB +: 8] <= hwdata[CTRL_BUS_LSB +: 8] & MASK_CTRL;
                  end
                endcase
              end
              OP_TAGRD: begin
                chan_q.ctl[CTL_ZERO_POS] <= 1'b1;
                state_q <= S_FWAIT;
              end
              OP_RDSEC: begin
                chan_q.tag_sel[TAG_CTRL_POS] <= 1'b1;
                chan_q.ctl[BUS_LSB + BUS_RGATE] <= 1'b1;
                chan_q.wdata <= WORD_ONES;
                cnt_q <= 18'(GAP_CYCLES);
                state_q <= S_GAP;
              end
              OP_WRSEC, OP_WRTAG: state_q <= S_SETWR;
              default: state_q <= S_IDLE;
            endcase
          end
        end
        S_GAP: begin
          if (cnt_q == 18'h00000) state_q <= S_ZSET;
          else cnt_q <= 18'(cnt_q - 18'h00001);
        end
        S_ZSET: begin
          chan_q.ctl[CTL_ZERO_POS] <= 1'b1;
          state_q <= S_ZCLR;
        end
        S_ZCLR: begin
          chan_q.ctl[CTL_ZERO_POS] <= 1'b0;
          cnt_q <= 18'(FLAG_TO_CYC);
          state_q <= S_FWAIT;
        end
        S_SETWR: begin
          chan_q.ctl[CTL_WRITE_POS] <= 1'b1;
          state_q <= S_SETER;
        end
        S_SETER: begin
          chan_q.ctl[BUS_LSB + BUS_ERASE] <= 1'b1;
          state_q <= S_SETWG;
        end
        S_SETWG: begin
          chan_q.ctl[BUS_LSB + BUS_WGATE] <= 1'b1;
          state_q <= S_SETTAG;
        end
        S_SETTAG: begin
          chan_q.tag_sel[TAG_CTRL_POS] <= 1'b1;
          cnt_q <= 18'(FLAG_TO_CYC);
          state_q <= S_FWAIT;
        end
        S_FWAIT: begin
          if (flag_rise) begin
            chan_q.ctl[CTL_RFLAG_POS] <= 1'b1;
            widx_q <= 8'(widx_q + 8'h01);
            state_q <= S_FACK;
            case (op_q)
              OP_RDSEC: begin
                if (widx_q < 8'(DATA_WORDS)) acc_q <= acc_q ^ dat_s2_q;
                else if ({dat_s2_q[7:0], dat_s2_q[15:8]} != acc_q) sts_q[ST_CERR] <= 1'b1;
              end
              OP_TAGRD: begin
                if (widx_q == 8'h00) begin
                  tag_rd_q <= dat_s2_q;
                  chan_q.ctl[CTL_ZERO_POS] <= 1'b0;
                end else if (dat_s2_q != ~tag_rd_q) sts_q[ST_CERR] <= 1'b1;
              end
              default: begin
                if (widx_q < op_len(op_q) - 8'h01) chan_q.wdata <= out_word;
                if (op_q == OP_WRSEC && widx_q >= 8'(GAP_WORDS + WS_SYNC)
                    && widx_q < 8'(GAP_WORDS + WS_SYNC + DATA_WORDS)) acc_q <= acc_q ^ buf_rd;
              end
            endcase
          end else if (cnt_q == 18'h00000) begin
            sts_q[ST_TOUT] <= 1'b1;
            state_q <= S_FIN;
          end else begin
            cnt_q <= 18'(cnt_q - 18'h00001);
          end
        end
        S_FACK: begin
          chan_q.ctl[CTL_RFLAG_POS] <= 1'b0;
          cnt_q <= 18'(FLAG_TO_CYC);
          state_q <= (widx_q == op_len(op_q)) ? S_FIN : S_FWAIT;
        end
        S_HOLD: begin
          if (cnt_q == 18'h00000) state_q <= S_FIN;
          else cnt_q <= 18'(cnt_q - 18'h00001);
        end
        S_FIN: begin
          chan_q.tag_sel <= 16'h0000;
          chan_q.ctl[CTL_WRITE_POS] <= 1'b0;
          chan_q.ctl[CTL_ZERO_POS] <= 1'b0;
          chan_q.ctl[CTL_RFLAG_POS] <= 1'b0;
          chan_q.ctl[BUS_LSB +: 8] <= 8'h00;
          if (op_q == OP_TAGRD && ctrl_q[CTRL_NEXTWR]) chan_q.wdata <= 16'h0000;
          else chan_q.wdata <= WORD_ONES;
          sts_q[ST_DONE] <= 1'b1;
          hwin_go <= ctrl_q[CTRL_HALF] && op_q != OP_TAGOUT && op_q != OP_TAGRD;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Half tracking restart window shown to software as a status bit
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) hwin_q <= 18'h00000;
    else if (hwin_go) hwin_q <= 18'(HWIN_CYCLES);
    else if (start || hwin_q == 18'h00000) hwin_q <= 18'h00000;
    else hwin_q <= 18'(hwin_q - 18'h00001);
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_q);
  sequence wr_setup_s;
    state_q == S_SETWR ##1 chan_q.ctl[CTL_WRITE_POS] && state_q == S_SETER;
  endsequence
  chk_rflag_pulse: assert property (flag_rise && state_q == S_FWAIT |=> chan_q.ctl[CTL_RFLAG_POS] ##1 !chan_q.ctl[CTL_RFLAG_POS])
    else $error("reset flag not a single pulse");
  chk_read_ones: assert property (op_q == OP_RDSEC && state_q != S_IDLE |-> chan_q.wdata == WORD_ONES)
    else $error("output word not all ones during read");
  chk_ctrl_bit3: assert property (chan_q.tag_sel[TAG_CTRL_POS] |-> !chan_q.ctl[BUS_LSB + 3])
    else $error("unused control bus bit driven");
  chk_sh_mask: assert property (chan_q.tag_sel[TAG_SECT_POS] || chan_q.tag_sel[TAG_HEAD_POS] |-> chan_q.ctl[BUS_LSB + 7 : BUS_LSB + 4] == 4'h0)
    else $error("sector or head tag with high bus bits");
  chk_write_order: assert property (wr_setup_s |=> chan_q.ctl[BUS_LSB + BUS_ERASE] ##1 chan_q.ctl[BUS_LSB + BUS_WGATE] ##1 chan_q.tag_sel[TAG_CTRL_POS])
    else $error("write setup order broken");
  chk_end_clear: assert property (state_q == S_FIN |=> chan_q.tag_sel == 16'h0000 && !chan_q.ctl[CTL_WRITE_POS] && chan_q.ctl[BUS_LSB +: 8] == 8'h00)
    else $error("controls not cleared at end");
  chk_flag_timeout: assert property (state_q == S_FWAIT && cnt_q == 18'h00000 && !flag_rise |=> sts_q[ST_TOUT] && state_q == S_FIN)
    else $error("flag wait not bounded");
  chk_unit_steady: assert property (state_q != S_IDLE && $past(state_q) != S_IDLE |-> $stable(chan_q.ctl[CTL_UNIT_LSB +: 3]))
    else $error("unit select moved during operation");
  chk_gap_wait: assert property ($rose(state_q == S_GAP) |-> cnt_q == 18'(GAP_CYCLES))
    else $error("head gap wait not loaded");
  chk_bus_wait: assert property (pend_q |-> !hreadyout ##1 hreadyout)
    else $error("bus data phase length wrong");

endmodule : dsts_host

/* verilog/dsts_pkg.sv */
// Purpose: Shared constants and types for the disk sector transfer sequencer
// Assumes: 125 MHz mclk; channel bit n (0 = most significant) sits at vector index 15-n
// Notes:   Register map, channel word fields, stream layouts and timing counts
package dsts_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS        = 8;
  localparam int GAP_NS        = 45000;      // Read/write to erase head gap, least time
  localparam int FLAG_TO_NS    = 18600;      // Word period plus flag timeout margin
  localparam int HALF_WIN_NS   = 1600000;    // Half tracking restart window, longest
  localparam int TAG_HOLD_NS   = 1000;       // Tag line hold for plain tag transfers
  localparam int GAP_CYC       = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLAG_TO_CYC   = FLAG_TO_NS / CLK_NS;
  localparam int HALF_WIN_CYC  = HALF_WIN_NS / CLK_NS;
  localparam int TAG_HOLD_CYC  = (TAG_HOLD_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // Register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_TAG      = 8'h08;
  localparam logic [7:0] REG_BUF_IDX  = 8'h0c;
  localparam logic [7:0] REG_BUF_DATA = 8'h10;
  localparam int CTRL_START  = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_HALF   = 4;
  localparam int CTRL_NEXTWR = 5;
  localparam int CTRL_UNIT_LSB = 6;
  localparam int CTRL_KIND_LSB = 9;
  localparam int CTRL_BUS_LSB  = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TOUT = 2;
  localparam int ST_CERR = 3;
  localparam int ST_HWIN = 4;

  // ****************************************************************
  // Channel word fields
  // ****************************************************************
  localparam int STS_FLAG_POS  = 7;   // Flag status in the drive status word
  localparam int CTL_RFLAG_POS = 7;   // Reset flag
  localparam int CTL_WRITE_POS = 4;   // Write direction
  localparam int CTL_ZERO_POS  = 3;   // Zeros search
  localparam int CTL_UNIT_LSB  = 0;   // Three unit select bits
  localparam int BUS_LSB       = 8;   // Address and control bus bit 0
  localparam int BUS_WGATE = 0;
  localparam int BUS_RGATE = 1;
  localparam int BUS_SEEKF = 2;
  localparam int BUS_ERASE = 4;
  localparam int BUS_SEEKR = 5;
  localparam int TAG_HEAD_POS = 3;
  localparam int TAG_DIFF_POS = 2;
  localparam int TAG_CTRL_POS = 1;
  localparam int TAG_SECT_POS = 0;
  localparam logic [7:0] MASK_DIFF = 8'h3f;
  localparam logic [7:0] MASK_SH   = 8'h0f;
  localparam logic [7:0] MASK_CTRL = 8'h37;

  // ****************************************************************
  // Stream layout
  // ****************************************************************
  localparam int DATA_WORDS = 104;
  localparam int GAP_WORDS  = 5;
  localparam int WS_SYNC    = 3;
  localparam int WT_SYNC    = 2;
  localparam logic [7:0] RD_LEN = 8'h69;   // 104 data plus checkword
  localparam logic [7:0] TR_LEN = 8'h02;   // Tag plus its complement
  localparam logic [7:0] WS_LEN = 8'h72;   // 114 words out
  localparam logic [7:0] WT_LEN = 8'h09;   // 9 words out
  localparam logic [15:0] WORD_ONES = 16'hffff;
  localparam logic [15:0] WORD_SYNC = 16'h0001;

  typedef enum logic [2:0] {OP_TAGOUT, OP_TAGRD, OP_RDSEC, OP_WRSEC, OP_WRTAG} dsts_op_type;

  typedef struct packed {
    logic [15:0] tag_sel;
    logic [15:0] ctl;
    logic [15:0] wdata;
  } dsts_chan_type;

  localparam dsts_chan_type CHAN_RST = '{tag_sel: 16'h0000, ctl: 16'h0000, wdata: WORD_ONES};

endpackage : dsts_pkg
